// >>> hw/srpc_consts.svh
// Constants for the soft reload partition controller
`ifndef SRPC_CONSTS_SVH
`define SRPC_CONSTS_SVH

// Special register space
`define SRPC_SFR_SPACE_BIT  7
`define SRPC_ADDR_TA_KEY    8'hC7
`define SRPC_ADDR_MEM_CTL   8'hC6
`define SRPC_ADDR_RANGE_CTL 8'hD8
`define SRPC_ADDR_PWR_CTL   8'h87

// Timed-access key bytes and window
`define SRPC_TA_KEY1        8'hAA
`define SRPC_TA_KEY2        8'h55
`define SRPC_TA_WINDOW      3'h3

// Memory control register fields
`define SRPC_MC_PSEL_HI     7
`define SRPC_MC_PSEL_LO     4
`define SRPC_MC_PAE_BIT     1
`define SRPC_MC_MISC_MASK   8'h0D
`define SRPC_PSEL_ZERO      4'h0
`define SRPC_PSEL_FULL      4'hF
`define SRPC_PSEL_RST       4'h8

// Range and port control register fields
`define SRPC_RC_NAE_BIT     4
`define SRPC_RC_MISC_MASK   8'hEF

// Power control register fields
`define SRPC_PC_STOP_BIT    1
`define SRPC_PC_PFIE_BIT    3
`define SRPC_PC_WDTE_BIT    2
`define SRPC_PC_MISC_MASK   8'hF1

// Memory map figures
`define SRPC_PART_OVR       17'h00800
`define SRPC_PART_NAE       17'h01000
`define SRPC_RANGE_NAE      17'h10000
`define SRPC_PART_TOP       17'h0FFFF
`define SRPC_PART_LOW_PAD   12'h000

`endif

// >>> hw/srpc_pkg.sv
// Types for the soft reload partition controller
package srpc_pkg;
  typedef enum logic [1:0] {
    TA_IDLE,
    TA_GOT_KEY1,
    TA_OPEN
  } srpc_ta_state_t;

  typedef logic [3:0]  srpc_psel_t;
  typedef logic [16:0] srpc_addr_t;
endpackage

// >>> hw/srpc_nv_store.sv
// Battery-backed holding register for the partition select field
`timescale 1ns/1ps
`include "srpc_consts.svh"

module srpc_nv_store (
  input  wire logic               clk,
  input  wire logic               nv_nrst,
  input  wire logic               load,
  input  wire srpc_pkg::srpc_psel_t load_val,
  output srpc_pkg::srpc_psel_t    psel
);

  srpc_pkg::srpc_psel_t psel_ff;

  // Loaded with 8 only by the battery-domain reset, never by the CPU reset
  always_ff @(posedge clk or negedge nv_nrst) begin
    if (!nv_nrst) begin
      psel_ff <= `SRPC_PSEL_RST;
    end else if (load) begin
      psel_ff <= load_val;
    end
  end

  assign psel = psel_ff;

endmodule // srpc_nv_store

// >>> hw/srpc_ctrl.sv
// Partition access control with timed-access protected special registers
`timescale 1ns/1ps
`include "srpc_consts.svh"

// How it works
// - While partition access enable is set and nonpartitionable access enable clear, partition is fixed at 0800h.
// - Partition select writes accepted while enable set; used after enable clears.
// - Partition access enable is memory control bit 1, timed-access protected.
// - During override in the partitionable map, addresses at or above 0800h are data and not fetchable.
// - During override, lowest 2kB stays executable program memory; all else unchanged.
// - External data moves reach RAM from partition up to below range.
// - Writes into the current program memory area are blocked; the code blocks them in the partitionable map only.
// - Clearing enable with unchanged select restores the earlier partition.
// - Variant without enable bit protects the partition select field by timed access.
// - Writing all-zero partition select is rejected.
// - Nonpartitionable access enable, range control bit 4, forces 64kB partitionable map.
// - With nonpartitionable access enable set, partition is 1000h.
// - Nonpartitionable access enable changes only after a timed-access sequence.
// - Stop bit, power control bit 1, changes only after timed access.
// - Power control bit 3 enables power-fail interrupt, bit 2 watchdog.
// - Special registers decode at 80h to FFh.
// - Partition select kept in battery-backed storage across CPU reset.
// - Partition select sits in memory control bits 7 to 4.

module srpc_ctrl (
  input  wire logic        CLK,
  input  wire logic        NRST,
  input  wire logic        NV_NRST,
  input  wire logic        NO_PAE_VARIANT,
  input  wire logic        CFG_PARTITIONABLE,
  input  wire logic [16:0] CFG_RANGE_ADDR,
  input  wire logic        SFR_WR,
  input  wire logic        SFR_RD,
  input  wire logic [7:0]  SFR_ADDR,
  input  wire logic [7:0]  SFR_WDATA,
  output logic [7:0]       SFR_RDATA,
  output logic             SFR_HIT,
  input  wire logic        FETCH_REQ,
  input  wire logic [15:0] FETCH_ADDR,
  output logic             FETCH_OK,
  input  wire logic        DATA_RD,
  input  wire logic        DATA_WR,
  input  wire logic [15:0] DATA_ADDR,
  output logic             DATA_OK,
  output logic             DATA_WR_BLOCKED,
  output logic             EXP_BUS_SEL,
  output logic [16:0]      PARTITION_ADDR,
  output logic             MAP_PARTITIONABLE,
  output logic             PART_ACCESS_EN,
  output logic             NONPART_ACCESS_EN,
  output logic             STOP_MODE,
  output logic             PFAIL_INT_EN,
  output logic             WDT_EN
);

  ////////////////////////////////////////////////////////////////////////////
  // Functions

  // Partition select code to partition address
  function automatic srpc_pkg::srpc_addr_t part_addr(input srpc_pkg::srpc_psel_t sel);
    if (sel == `SRPC_PSEL_FULL) begin
      part_addr = `SRPC_PART_TOP;
    end else begin
      part_addr = {1'b0, sel, `SRPC_PART_LOW_PAD};
    end
  endfunction

  // Special register decode within 80h..FFh
  function automatic logic sfr_is(input logic [7:0] addr, input logic [7:0] target);
    sfr_is = addr[`SRPC_SFR_SPACE_BIT] && (addr == target);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Declarations

  srpc_pkg::srpc_ta_state_t ta_state_ff;
  srpc_pkg::srpc_ta_state_t nxt_ta_state;
  logic [2:0]               ta_cnt_ff;
  logic [2:0]               nxt_ta_cnt;
  logic                     ta_open;
  logic                     pae_ff;
  logic                     nae_ff;
  logic                     stop_ff;
  logic                     pfie_ff;
  logic                     wdte_ff;
  logic [7:0]               mc_misc_ff;
  logic [7:0]               rc_misc_ff;
  logic [7:0]               pc_misc_ff;
  logic [7:0]               rdata_ff;
  logic                     hit_ff;
  logic                     fetch_ok_ff;
  logic                     data_ok_ff;
  logic                     wr_blk_ff;
  logic                     exp_ff;
  logic                     wr_ta;
  logic                     wr_mc;
  logic                     wr_rc;
  logic                     wr_pc;
  logic                     wr_prot;
  logic                     psel_load;
  srpc_pkg::srpc_psel_t     psel;
  srpc_pkg::srpc_psel_t     wr_psel;
  srpc_pkg::srpc_addr_t     eff_part;
  srpc_pkg::srpc_addr_t     eff_range;
  srpc_pkg::srpc_addr_t     fetch_a;
  srpc_pkg::srpc_addr_t     data_a;
  logic                     partitionable;
  logic                     pae_active;

  ////////////////////////////////////////////////////////////////////////////
  // Register decode

  assign wr_ta   = SFR_WR && sfr_is(SFR_ADDR, `SRPC_ADDR_TA_KEY);
  assign wr_mc   = SFR_WR && sfr_is(SFR_ADDR, `SRPC_ADDR_MEM_CTL);
  assign wr_rc   = SFR_WR && sfr_is(SFR_ADDR, `SRPC_ADDR_RANGE_CTL);
  assign wr_pc   = SFR_WR && sfr_is(SFR_ADDR, `SRPC_ADDR_PWR_CTL);
  assign wr_prot = wr_mc || wr_rc || wr_pc;
  assign wr_psel = SFR_WDATA[`SRPC_MC_PSEL_HI:`SRPC_MC_PSEL_LO];

  ////////////////////////////////////////////////////////////////////////////
  // Timed-access key tracker

  assign ta_open = (ta_state_ff == srpc_pkg::TA_OPEN);

  always_comb begin
    nxt_ta_state = ta_state_ff;
    nxt_ta_cnt   = ta_cnt_ff;
    case (ta_state_ff)
      srpc_pkg::TA_IDLE: begin
        if (wr_ta && (SFR_WDATA == `SRPC_TA_KEY1)) begin
          nxt_ta_state = srpc_pkg::TA_GOT_KEY1;
        end
      end
      srpc_pkg::TA_GOT_KEY1: begin
        if (wr_ta && (SFR_WDATA == `SRPC_TA_KEY2)) begin
          nxt_ta_state = srpc_pkg::TA_OPEN;
          nxt_ta_cnt   = `SRPC_TA_WINDOW;
        end else if (SFR_WR) begin
          nxt_ta_state = srpc_pkg::TA_IDLE;
        end
      end
      srpc_pkg::TA_OPEN: begin
        // Window closes on a protected write, a new key, or timeout
        if (wr_prot || wr_ta || (ta_cnt_ff == 3'h1)) begin
          nxt_ta_state = srpc_pkg::TA_IDLE;
          nxt_ta_cnt   = 3'h0;
        end else begin
          nxt_ta_cnt = ta_cnt_ff - 3'h1;
        end
      end
      default: begin
        nxt_ta_state = srpc_pkg::TA_IDLE;
        nxt_ta_cnt   = 3'h0;
      end
    endcase
  end

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      ta_state_ff <= srpc_pkg::TA_IDLE;
      ta_cnt_ff   <= 3'h0;
    end else begin
      ta_state_ff <= nxt_ta_state;
      ta_cnt_ff   <= nxt_ta_cnt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Memory control register

  // Select accepted while enable set, or by timed access in the variant
  assign psel_load = wr_mc
                  && (wr_psel != `SRPC_PSEL_ZERO)
                  && (NO_PAE_VARIANT ? ta_open : pae_ff);

  srpc_nv_store u_nv_store (
    .clk      (CLK),
    .nv_nrst  (NV_NRST),
    .load     (psel_load),
    .load_val (wr_psel),
    .psel     (psel)
  );

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      pae_ff <= 1'b0;
    end else if (wr_mc && ta_open && !NO_PAE_VARIANT) begin
      pae_ff <= SFR_WDATA[`SRPC_MC_PAE_BIT];
    end
  end

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      mc_misc_ff <= 8'h00;
    end else if (wr_mc) begin
      mc_misc_ff <= SFR_WDATA & `SRPC_MC_MISC_MASK;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Range and port control register

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      nae_ff <= 1'b0;
    end else if (wr_rc && ta_open) begin
      nae_ff <= SFR_WDATA[`SRPC_RC_NAE_BIT];
    end
  end

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      rc_misc_ff <= 8'h00;
    end else if (wr_rc) begin
      rc_misc_ff <= SFR_WDATA & `SRPC_RC_MISC_MASK;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Power control register

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      stop_ff <= 1'b0;
    end else if (wr_pc && ta_open) begin
      stop_ff <= SFR_WDATA[`SRPC_PC_STOP_BIT];
    end
  end

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      pfie_ff    <= 1'b0;
      wdte_ff    <= 1'b0;
      pc_misc_ff <= 8'h00;
    end else if (wr_pc) begin
      pfie_ff    <= SFR_WDATA[`SRPC_PC_PFIE_BIT];
      wdte_ff    <= SFR_WDATA[`SRPC_PC_WDTE_BIT];
      pc_misc_ff <= SFR_WDATA & `SRPC_PC_MISC_MASK;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register read-back

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      rdata_ff <= 8'h00;
      hit_ff   <= 1'b0;
    end else if (SFR_RD) begin
      hit_ff   <= 1'b1;
      rdata_ff <= 8'h00;
      if (sfr_is(SFR_ADDR, `SRPC_ADDR_MEM_CTL)) begin
        rdata_ff <= mc_misc_ff;
        rdata_ff[`SRPC_MC_PSEL_HI:`SRPC_MC_PSEL_LO] <= psel;
        rdata_ff[`SRPC_MC_PAE_BIT] <= pae_ff;
      end else if (sfr_is(SFR_ADDR, `SRPC_ADDR_RANGE_CTL)) begin
        rdata_ff <= rc_misc_ff;
        rdata_ff[`SRPC_RC_NAE_BIT] <= nae_ff;
      end else if (sfr_is(SFR_ADDR, `SRPC_ADDR_PWR_CTL)) begin
        rdata_ff <= pc_misc_ff;
        rdata_ff[`SRPC_PC_STOP_BIT] <= stop_ff;
        rdata_ff[`SRPC_PC_PFIE_BIT] <= pfie_ff;
        rdata_ff[`SRPC_PC_WDTE_BIT] <= wdte_ff;
      end else if (!sfr_is(SFR_ADDR, `SRPC_ADDR_TA_KEY)) begin
        hit_ff <= 1'b0;
      end
    end else begin
      hit_ff <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Effective memory map

  assign pae_active    = pae_ff && !NO_PAE_VARIANT;
  assign partitionable = CFG_PARTITIONABLE || nae_ff;
  assign eff_range     = nae_ff ? `SRPC_RANGE_NAE : CFG_RANGE_ADDR;

  // Override partitions win over the stored select, which is kept intact
  always_comb begin
    if (nae_ff) begin
      eff_part = `SRPC_PART_NAE;
    end else if (pae_active) begin
      eff_part = `SRPC_PART_OVR;
    end else begin
      eff_part = part_addr(psel);
    end
  end

  assign fetch_a = {1'b0, FETCH_ADDR};
  assign data_a  = {1'b0, DATA_ADDR};

  ////////////////////////////////////////////////////////////////////////////
  // Access decisions

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      fetch_ok_ff <= 1'b0;
    end else if (FETCH_REQ) begin
      if (partitionable) begin
        fetch_ok_ff <= fetch_a < eff_part;
      end else begin
        fetch_ok_ff <= fetch_a < eff_range;
      end
    end else begin
      fetch_ok_ff <= 1'b0;
    end
  end

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      data_ok_ff <= 1'b0;
      wr_blk_ff  <= 1'b0;
      exp_ff     <= 1'b0;
    end else if (DATA_RD || DATA_WR) begin
      exp_ff <= data_a >= eff_range;
      if (partitionable) begin
        data_ok_ff <= (data_a >= eff_part) && (data_a < eff_range);
        wr_blk_ff  <= DATA_WR && (data_a < eff_part);
      end else begin
        data_ok_ff <= data_a < eff_range;
        wr_blk_ff  <= 1'b0;
      end
    end else begin
      data_ok_ff <= 1'b0;
      wr_blk_ff  <= 1'b0;
      exp_ff     <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign SFR_RDATA         = rdata_ff;
  assign SFR_HIT           = hit_ff;
  assign FETCH_OK          = fetch_ok_ff;
  assign DATA_OK           = data_ok_ff;
  assign DATA_WR_BLOCKED   = wr_blk_ff;
  assign EXP_BUS_SEL       = exp_ff;
  assign PARTITION_ADDR    = eff_part;
  assign MAP_PARTITIONABLE = partitionable;
  assign PART_ACCESS_EN    = pae_ff;
  assign NONPART_ACCESS_EN = nae_ff;
  assign STOP_MODE         = stop_ff;
  assign PFAIL_INT_EN      = pfie_ff;
  assign WDT_EN            = wdte_ff;

endmodule // srpc_ctrl

// >>> test/srpc_ctrl_properties.sv
// Port-level assertions for the partition controller
`timescale 1ns/1ps

module srpc_chk (
  input wire logic        CLK,
  input wire logic        NRST,
  input wire logic        NO_PAE_VARIANT,
  input wire logic        SFR_WR,
  input wire logic        SFR_RD,
  input wire logic [7:0]  SFR_ADDR,
  input wire logic [7:0]  SFR_WDATA,
  input wire logic        SFR_HIT,
  input wire logic        FETCH_REQ,
  input wire logic [15:0] FETCH_ADDR,
  input wire logic        FETCH_OK,
  input wire logic        DATA_WR,
  input wire logic [15:0] DATA_ADDR,
  input wire logic        DATA_WR_BLOCKED,
  input wire logic [16:0] PARTITION_ADDR,
  input wire logic        MAP_PARTITIONABLE,
  input wire logic        PART_ACCESS_EN,
  input wire logic        NONPART_ACCESS_EN,
  input wire logic        STOP_MODE,
  input wire logic        PFAIL_INT_EN,
  input wire logic        WDT_EN
);
  logic key_done;
  // Second key byte taken this cycle
  assign key_done = SFR_WR && SFR_ADDR == 8'hC7 && SFR_WDATA == 8'h55;
  default clocking dc @(posedge CLK); endclocking
  default disable iff (!NRST);
  ////////////////////////////////////////////////////////////////////////////////
  property p_part_ovr;
    PART_ACCESS_EN && !NONPART_ACCESS_EN && !NO_PAE_VARIANT |-> PARTITION_ADDR == 17'h00800;
  endproperty
  a_part_ovr: assert property (p_part_ovr) else $error("override partition wrong");
  property p_nae_map;
    NONPART_ACCESS_EN |-> MAP_PARTITIONABLE && PARTITION_ADDR == 17'h01000;
  endproperty
  a_nae_map: assert property (p_nae_map) else $error("nonpart map wrong");
  property p_fetch;
    FETCH_REQ && MAP_PARTITIONABLE |=>
      FETCH_OK == ({1'b0, $past(FETCH_ADDR)} < $past(PARTITION_ADDR));
  endproperty
  a_fetch: assert property (p_fetch) else $error("fetch decision wrong");
  property p_blk;
    DATA_WR && MAP_PARTITIONABLE |=>
      DATA_WR_BLOCKED == ({1'b0, $past(DATA_ADDR)} < $past(PARTITION_ADDR));
  endproperty
  a_blk: assert property (p_blk) else $error("write block wrong");
  property p_pae_key;
    $changed(PART_ACCESS_EN) |-> $past(key_done, 2) || $past(key_done, 3) || $past(key_done, 4);
  endproperty
  a_pae_key: assert property (p_pae_key) else $error("enable changed without key");
  property p_nae_key;
    $changed(NONPART_ACCESS_EN) |-> $past(key_done, 2) || $past(key_done, 3) || $past(key_done, 4);
  endproperty
  a_nae_key: assert property (p_nae_key) else $error("nonpart changed without key");
  property p_stop_key;
    $changed(STOP_MODE) |-> $past(key_done, 2) || $past(key_done, 3) || $past(key_done, 4);
  endproperty
  a_stop_key: assert property (p_stop_key) else $error("stop changed without key");
  property p_pwr;
    SFR_WR && SFR_ADDR == 8'h87 |=>
      PFAIL_INT_EN == $past(SFR_WDATA[3]) && WDT_EN == $past(SFR_WDATA[2]);
  endproperty
  a_pwr: assert property (p_pwr) else $error("power bits wrong");
  property p_nz;
    PARTITION_ADDR != 17'h00000;
  endproperty
  a_nz: assert property (p_nz) else $error("zero partition");
  property p_hit;
    SFR_RD && !SFR_ADDR[7] |=> !SFR_HIT;
  endproperty
  a_hit: assert property (p_hit) else $error("hit below special space");
endmodule // srpc_chk

bind srpc_ctrl srpc_chk u_chk (
  .CLK(CLK), .NRST(NRST), .NO_PAE_VARIANT(NO_PAE_VARIANT),
  .SFR_WR(SFR_WR), .SFR_RD(SFR_RD), .SFR_ADDR(SFR_ADDR),
  .SFR_WDATA(SFR_WDATA), .SFR_HIT(SFR_HIT), .FETCH_REQ(FETCH_REQ), .FETCH_ADDR(FETCH_ADDR),
  .FETCH_OK(FETCH_OK), .DATA_WR(DATA_WR), .DATA_ADDR(DATA_ADDR),
  .DATA_WR_BLOCKED(DATA_WR_BLOCKED), .PARTITION_ADDR(PARTITION_ADDR),
  .MAP_PARTITIONABLE(MAP_PARTITIONABLE), .PART_ACCESS_EN(PART_ACCESS_EN),
  .NONPART_ACCESS_EN(NONPART_ACCESS_EN), .STOP_MODE(STOP_MODE),
  .PFAIL_INT_EN(PFAIL_INT_EN), .WDT_EN(WDT_EN));

// >>> test/tb.sv
// Self-checking bench for the partition controller
`timescale 1ns/1ps

module tb;
  logic        CLK, NRST, NV_NRST, NO_PAE_VARIANT, CFG_PARTITIONABLE, SFR_WR, SFR_RD;
  logic        FETCH_REQ, DATA_RD, DATA_WR, SFR_HIT, FETCH_OK, DATA_OK, DATA_WR_BLOCKED;
  logic        EXP_BUS_SEL, MAP_PARTITIONABLE, PART_ACCESS_EN, NONPART_ACCESS_EN;
  logic        STOP_MODE, PFAIL_INT_EN, WDT_EN;
  logic [7:0]  SFR_ADDR, SFR_WDATA, SFR_RDATA;
  logic [15:0] FETCH_ADDR, DATA_ADDR;
  logic [16:0] CFG_RANGE_ADDR, PARTITION_ADDR;
  logic [31:0] r;
  logic [7:0]  ra [7] = '{8'h40, 8'h87, 8'hC6, 8'hC7, 8'hD8, 8'h80, 8'hFF};
  int          sel, pae, nae, stp, pf, wd, mcm, rcm, pcm, k1, k2, k2t, miscompares, compares;

  srpc_ctrl dut (
    .CLK(CLK), .NRST(NRST), .NV_NRST(NV_NRST), .NO_PAE_VARIANT(NO_PAE_VARIANT),
    .CFG_PARTITIONABLE(CFG_PARTITIONABLE), .CFG_RANGE_ADDR(CFG_RANGE_ADDR),
    .SFR_WR(SFR_WR), .SFR_RD(SFR_RD), .SFR_ADDR(SFR_ADDR), .SFR_WDATA(SFR_WDATA),
    .SFR_RDATA(SFR_RDATA), .SFR_HIT(SFR_HIT), .FETCH_REQ(FETCH_REQ),
    .FETCH_ADDR(FETCH_ADDR), .FETCH_OK(FETCH_OK), .DATA_RD(DATA_RD), .DATA_WR(DATA_WR),
    .DATA_ADDR(DATA_ADDR), .DATA_OK(DATA_OK), .DATA_WR_BLOCKED(DATA_WR_BLOCKED),
    .EXP_BUS_SEL(EXP_BUS_SEL), .PARTITION_ADDR(PARTITION_ADDR),
    .MAP_PARTITIONABLE(MAP_PARTITIONABLE), .PART_ACCESS_EN(PART_ACCESS_EN),
    .NONPART_ACCESS_EN(NONPART_ACCESS_EN), .STOP_MODE(STOP_MODE),
    .PFAIL_INT_EN(PFAIL_INT_EN), .WDT_EN(WDT_EN));

  always #50 CLK = ~CLK;
  ////////////////////////////////////////////////////////////////////////////////
  function int part();
    if (nae) return 'h1000;
    if (pae && !NO_PAE_VARIANT) return 'h800;
    return sel == 15 ? 'hFFFF : sel << 12;
  endfunction

  task end_sim();
    if (miscompares == 0 && compares > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task cmp(input logic [16:0] got, input logic [16:0] exp);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task chk();
    cmp(PARTITION_ADDR, part());
    cmp(PART_ACCESS_EN, pae);
    cmp(NONPART_ACCESS_EN, nae);
    cmp(MAP_PARTITIONABLE, CFG_PARTITIONABLE | nae);
    cmp(STOP_MODE, stp);
    cmp(PFAIL_INT_EN, pf);
    cmp(WDT_EN, wd);
  endtask

  task clr();
    {pae, nae, stp, pf, wd, mcm, rcm, pcm, k1, k2} = '0;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task wr(input logic [7:0] a, input logic [7:0] d);
    int ok;
    @(posedge CLK);
    SFR_WR <= 1;
    SFR_ADDR <= a;
    SFR_WDATA <= d;
    @(posedge CLK);
    SFR_WR <= 0;
    ok = k2 && $time / 100 - k2t <= 3;
    if (a inside {8'hC6, 8'hC7, 8'hD8, 8'h87}) k2 = 0;
    if (a == 8'hC7 && d == 8'h55 && k1) begin
      k2 = 1;
      k2t = $time / 100;
    end
    // First key byte only counts from the idle state
    k1 = a == 8'hC7 && d == 8'hAA && !k1 && !ok;
    if (a == 8'hC6) begin
      if ((NO_PAE_VARIANT ? ok : pae) && d[7:4] != 0) sel = d[7:4];
      if (ok && !NO_PAE_VARIANT) pae = d[1];
      mcm = d & 8'h0D;
    end
    if (a == 8'hD8) begin
      if (ok) nae = d[4];
      rcm = d & 8'hEF;
    end
    if (a == 8'h87) begin
      if (ok) stp = d[1];
      pf = d[3];
      wd = d[2];
      pcm = d & 8'hF1;
    end
    #1 chk();
  endtask

  task key();
    wr(8'hC7, 8'hAA);
    wr(8'hC7, 8'h55);
  endtask

  task rd(input logic [7:0] a);
    logic [7:0] e;
    @(posedge CLK);
    SFR_RD <= 1;
    SFR_ADDR <= a;
    @(posedge CLK);
    SFR_RD <= 0;
    e = a == 8'hC6 ? 8'(sel << 4 | mcm | pae << 1) : a == 8'hD8 ? 8'(rcm | nae << 4) :
        a == 8'h87 ? 8'(pcm | pf << 3 | wd << 2 | stp << 1) : 8'h00;
    #1 cmp(SFR_HIT, a inside {8'hC6, 8'hC7, 8'hD8, 8'h87});
    cmp(SFR_RDATA, e);
  endtask

  // Kind 0 fetch, 1 data read, 2 data write
  task mem(input int k, input logic [15:0] a);
    int p, rg, mp;
    @(posedge CLK);
    FETCH_REQ <= k == 0;
    DATA_RD <= k == 1;
    DATA_WR <= k == 2;
    FETCH_ADDR <= a;
    DATA_ADDR <= a;
    p = part();
    rg = nae ? 'h10000 : CFG_RANGE_ADDR;
    mp = CFG_PARTITIONABLE | nae;
    @(posedge CLK);
    {FETCH_REQ, DATA_RD, DATA_WR} <= 3'h0;
    #1;
    if (k == 0) cmp(FETCH_OK, mp ? a < p : a < rg);
    else begin
      cmp(DATA_OK, mp ? a >= p && a < rg : a < rg);
      cmp(DATA_WR_BLOCKED, k == 2 && mp && a < p);
      cmp(EXP_BUS_SEL, a >= rg);
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    #2000000;
    miscompares++;
    end_sim();
  end

  initial begin
    {CLK, NRST, NV_NRST, NO_PAE_VARIANT, SFR_WR, SFR_RD, FETCH_REQ, DATA_RD, DATA_WR} = '0;
    {SFR_ADDR, SFR_WDATA, FETCH_ADDR, DATA_ADDR} = '0;
    CFG_PARTITIONABLE = 1;
    CFG_RANGE_ADDR = 17'h10000;
    sel = 8;
    r = $urandom(32'hD8C5);
    repeat (2) @(posedge CLK);
    NV_NRST <= 1;
    repeat (8) @(posedge CLK);
    NRST <= 1;
    #1 chk();
    mem(0, 16'h7FFF); mem(0, 16'h8000); mem(2, 16'h7FFF); mem(1, 16'h8000);
    wr(8'hC6, 8'h8A);
    key(); wr(8'hC6, 8'h8A);
    mem(0, 16'h07FF); mem(0, 16'h0800); mem(2, 16'h0800); mem(2, 16'h07FF);
    wr(8'hC6, 8'h0A);
    key(); wr(8'hC6, 8'h88);
    key(); wr(8'hC6, 8'h8A); wr(8'hC6, 8'hCA);
    key(); repeat (3) @(posedge CLK); wr(8'hC6, 8'hC8);
    key(); wr(8'hC6, 8'hC8);
    wr(8'hC7, 8'hAA); wr(8'h87, 8'h00); wr(8'hC7, 8'h55); wr(8'h87, 8'h02);
    @(posedge CLK) NO_PAE_VARIANT <= 1;
    wr(8'hC6, 8'h30); key(); wr(8'hC6, 8'h30);
    key(); wr(8'hC6, 8'h00); key(); wr(8'hC6, 8'hF0); mem(0, 16'hFFFE);
    @(posedge CLK) CFG_PARTITIONABLE <= 0;
    mem(0, 16'hF000); mem(1, 16'h0100); wr(8'hD8, 8'h10);
    key(); wr(8'hD8, 8'hFF);
    mem(0, 16'h1000); mem(2, 16'h0FFF); mem(1, 16'h1000); wr(8'hD8, 8'h00);
    key(); wr(8'hD8, 8'h00);
    wr(8'h87, 8'h0E); key(); wr(8'h87, 8'hF2);
    foreach (ra[i]) rd(ra[i]);
    // Two edges low so the reset drop is masked from the change checks
    @(posedge CLK) NRST <= 0;
    repeat (2) @(posedge CLK);
    NRST <= 1;
    clr();
    #1 chk();
    @(posedge CLK) CFG_PARTITIONABLE <= 1;
    repeat (60) begin
      r = $urandom;
      if (r[2:0] == 0) begin
        key();
        wr(8'hC6, r[15:8] & 8'hF0);
      end else
        mem(r[9:8] % 3, r[31:16]);
    end
    end_sim();
  end
endmodule // tb
